// ==== src/atam_arb.sv ====
`timescale 1ns/1ns
module atam_arb #(
  parameter int NUM   = 4,
  parameter int PRI_W = 2
) (
  input  wire logic [NUM-1:0]       request,  // pending triggers
  input  wire logic [NUM*PRI_W-1:0] level,    // per-sequencer level
  output logic                      anyGrant, // a winner exists
  output logic [1:0]                grantIdx  // winning sequencer
);

  generate
    if (NUM > 4 || NUM < 1) begin : g_bad
      $error("atam_arb supports 1 to 4 sequencers");
    end
  endgenerate

  logic [NUM-1:0] wins;

  // a request wins if no other request has a lower level; equal
  // levels are illegal setups, lowest index breaks them anyway
  genvar i, j;
  generate
    for (i = 0; i < NUM; i++) begin : g_cand
      logic [NUM-1:0] beaten;
      for (j = 0; j < NUM; j++) begin : g_vs
        if (j == i) begin : g_self
          assign beaten[j] = 1'b0;
        end else begin : g_other
          wire [PRI_W-1:0] pi = level[i*PRI_W +: PRI_W];
          wire [PRI_W-1:0] pj = level[j*PRI_W +: PRI_W];
          assign beaten[j] = request[j] &&
                             ((pj < pi) || ((pj == pi) && (j < i)));
        end
      end
      assign wins[i] = request[i] && (beaten == '0);
    end
  endgenerate

  // encode the single winner
  always_comb begin
    grantIdx = 2'h0;
    for (int k = 0; k < NUM; k++) begin
      if (wins[k]) begin
        grantIdx = 2'(k);
      end
    end
  end

  assign anyGrant = |request;

endmodule : atam_arb

// ==== src/atam_avg.sv ====
`timescale 1ns/1ns
module atam_avg #(
  parameter int SAMPLE_W = 10,
  parameter int EXP_W    = 3,
  parameter int MAX_EXP  = 6
) (
  input  wire logic                clk,         // system clock
  input  wire logic                rst_n,       // async reset, low
  input  wire logic [EXP_W-1:0]    exponent,    // log2 of sample count
  input  wire logic                sampleValid, // one conversion done
  input  wire logic [SAMPLE_W-1:0] sampleData,  // conversion value
  output logic                     lastSample,  // next sample closes
  output logic                     resultValid, // one-cycle pulse
  output logic [SAMPLE_W-1:0]      resultData   // averaged value
);

  generate
    if (MAX_EXP >= (1 << EXP_W) || MAX_EXP < 1) begin : g_bad
      $error("atam_avg: MAX_EXP does not fit the exponent field");
    end
  endgenerate

  localparam int ACC_W = SAMPLE_W + MAX_EXP;

  logic [ACC_W-1:0]   acc;
  logic [MAX_EXP-1:0] count;

  wire [MAX_EXP-1:0] countMask = ~({MAX_EXP{1'b1}} << exponent);
  wire [ACC_W-1:0]   sum       = acc + ACC_W'(sampleData);
  wire [ACC_W-1:0]   scaled    = sum >> exponent;
  // with exponent zero the mask is zero: every sample closes at once
  assign lastSample = (count == countMask);

  // accumulate, then divide by the power of two on the closing sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc         <= '0;
      count       <= '0;
      resultValid <= 1'b0;
      resultData  <= '0;
    end else begin
      resultValid <= sampleValid && lastSample;
      if (sampleValid && lastSample) begin
        acc        <= '0;
        count      <= '0;
        resultData <= scaled[SAMPLE_W-1:0];
      end else if (sampleValid) begin
        acc   <= sum;
        count <= count + 1'b1;
      end
    end
  end

endmodule : atam_avg

// ==== src/atam_pkg.sv ====
package atam_pkg;

  // register byte offsets on the 32-bit bus
  localparam logic [7:0] OFF_ENABLE    = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_SEQ0_LAST = 8'h08;
  localparam logic [7:0] OFF_PRIORITY  = 8'h20;
  localparam logic [7:0] OFF_INITIATE  = 8'h28;
  localparam logic [7:0] OFF_AVG       = 8'h30;
  localparam logic [7:0] OFF_INPUT_SELECT_SLOT0      = 8'h40;

  // geometry
  localparam int NUM_SEQ      = 4;
  localparam int SLOTS        = 8;
  localparam int SLOT_W       = 3;
  localparam int SEL_W        = 2;
  localparam int PRI_W        = 2;
  localparam int EXP_W        = 3;
  localparam int SAMPLE_W     = 10;
  localparam int FIELD_STRIDE = 4;
  localparam int MAX_EXP      = 6;

  // status register field positions
  localparam int ST_PEND_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_SEQ_LSB  = 8;
  localparam int ST_SLOT_LSB = 12;

  // reset values
  localparam logic [3:0]  RST_ENABLE   = 4'h0;
  localparam logic [31:0] RST_PRIORITY = 32'h0000_3210;
  localparam logic [2:0]  RST_AVG      = 3'h0;
  localparam logic [31:0] RST_INPUT_SELECT_SLOT0     = 32'h0000_0000;
  localparam logic [2:0]  RST_LAST     = 3'h7;

  // writable-bit masks
  localparam logic [31:0] MASK_PRIORITY = 32'h0000_3333;
  localparam logic [31:0] MASK_INPUT_SELECT_SLOT0     = 32'h3333_3333;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencing states, gray along idle-start-wait-next
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b11,
    ST_NEXT  = 2'b10
  } atam_state_e;

  // conversion request to the analog converter
  typedef struct packed {
    logic             start;
    logic [SEL_W-1:0] channel;
  } atam_conv_s;

  // averaged result bound for a sequencer fifo
  typedef struct packed {
    logic [1:0]          seq;
    logic [SLOT_W-1:0]   slot;
    logic [SAMPLE_W-1:0] data;
  } atam_result_s;

endpackage : atam_pkg

// ==== src/atam_top.sv ====
`timescale 1ns/1ns
// Overview of operation
// - initiate bit n starts enabled sequencer n
// - one write may trigger any combination
// - simultaneous triggers run in priority order
// - initiate register write-only, reads harmless
// - result averages two-to-exponent conversions for exponents zero to six; exponent seven sums sixty-four and divides by 128
// - exponent zero passes conversions straight through
// - exponent six averages sixty-four conversions
// - eight two-bit slot selects, stride four
// - sequencer 0 slot k converts input named by select
// - two-bit priority, zero highest, three lowest
module atam_top (
  input  wire logic         clk,        // system clock, 20 MHz
  input  wire logic         rst_n,      // async reset, active low
  // axi4-lite slave
  input  wire logic [7:0]   s_awaddr,   // write address
  input  wire logic         s_awvalid,  // write address valid
  output logic              s_awready,  // write address ready
  input  wire logic [31:0]  s_wdata,    // write data
  input  wire logic [3:0]   s_wstrb,    // write byte strobes
  input  wire logic         s_wvalid,   // write data valid
  output logic              s_wready,   // write data ready
  output logic [1:0]        s_bresp,    // write response
  output logic              s_bvalid,   // write response valid
  input  wire logic         s_bready,   // write response ready
  input  wire logic [7:0]   s_araddr,   // read address
  input  wire logic         s_arvalid,  // read address valid
  output logic              s_arready,  // read address ready
  output logic [31:0]       s_rdata,    // read data
  output logic [1:0]        s_rresp,    // read response
  output logic              s_rvalid,   // read data valid
  input  wire logic         s_rready,   // read data ready
  // analog converter
  output atam_pkg::atam_conv_s convReq, // start pulse and channel
  input  wire logic         convDone,   // conversion finished pulse
  input  wire logic [atam_pkg::SAMPLE_W-1:0] convData, // raw value
  // sequencer fifo side
  output atam_pkg::atam_result_s result, // averaged result
  output logic              resultValid, // one-cycle pulse
  output logic              busy        // a sequence is running
);

  // ---- register state
  logic [atam_pkg::NUM_SEQ-1:0] activeSequencerEnable;
  logic [31:0]                  sequencerPriority;
  logic [atam_pkg::EXP_W-1:0]   averagingExponent;
  logic [31:0]                  seq0InputSelect;
  logic [atam_pkg::SLOT_W-1:0]  seq0LastSlot;
  logic [atam_pkg::NUM_SEQ-1:0] pending;

  // ---- sequencing state
  atam_pkg::atam_state_e        state;
  atam_pkg::atam_state_e        next_state;
  logic [1:0]                   curSeq;
  logic [atam_pkg::SLOT_W-1:0]  curSlot;
  logic [atam_pkg::EXP_W-1:0]   curExp;

  // ---- write channel holding registers
  logic        awHeld;
  logic [7:0]  awAddr;
  logic        wHeld;
  logic [31:0] wData;
  logic [3:0]  wStrb;

  // ---- write path
  // address and data may arrive in either order; each is held
  // until both are present and no response is still outstanding
  assign s_awready = !awHeld;
  assign s_wready  = !wHeld;

  wire awTake   = s_awvalid && s_awready;
  wire wTake    = s_wvalid && s_wready;
  wire doWrite  = awHeld && wHeld && !s_bvalid;

  wire selEnW   = doWrite && (awAddr == atam_pkg::OFF_ENABLE);
  wire selLastW = doWrite && (awAddr == atam_pkg::OFF_SEQ0_LAST);
  wire selPriW  = doWrite && (awAddr == atam_pkg::OFF_PRIORITY);
  wire selIniW  = doWrite && (awAddr == atam_pkg::OFF_INITIATE);
  wire selAvgW  = doWrite && (awAddr == atam_pkg::OFF_AVG);
  wire selMuxW  = doWrite && (awAddr == atam_pkg::OFF_INPUT_SELECT_SLOT0);
  wire selStW   = doWrite && (awAddr == atam_pkg::OFF_STATUS);
  wire wMapped  = selEnW || selLastW || selPriW || selIniW ||
                  selAvgW || selMuxW || selStW;

  // byte-lane mask built from the strobes
  wire [31:0] laneMask = {{8{wStrb[3]}}, {8{wStrb[2]}},
                          {8{wStrb[1]}}, {8{wStrb[0]}}};

  // merged values for the read/write registers
  wire [31:0] mergedPri = ((sequencerPriority & ~laneMask) |
                           (wData & laneMask)) & atam_pkg::MASK_PRIORITY;
  wire [31:0] mergedMux = ((seq0InputSelect & ~laneMask) |
                           (wData & laneMask)) & atam_pkg::MASK_INPUT_SELECT_SLOT0;

  // trigger bits from one write, any combination at once
  wire [atam_pkg::NUM_SEQ-1:0] trigWrite =
    (selIniW && wStrb[0]) ? wData[atam_pkg::NUM_SEQ-1:0]
                          : '0;

  // a trigger for a disabled sequencer is dropped
  wire [atam_pkg::NUM_SEQ-1:0] trigSet =
    trigWrite & activeSequencerEnable;

  // write address and data capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= 8'h00;
      wHeld  <= 1'b0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end else begin
      if (awTake) begin
        awHeld <= 1'b1;
        awAddr <= {s_awaddr[7:2], 2'b00};
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (wTake) begin
        wHeld <= 1'b1;
        wData <= s_wdata;
        wStrb <= s_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer with slave error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= atam_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wMapped ? atam_pkg::RESP_OKAY : atam_pkg::RESP_SLVERR;
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeSequencerEnable <= atam_pkg::RST_ENABLE;
      sequencerPriority     <= atam_pkg::RST_PRIORITY;
      averagingExponent     <= atam_pkg::RST_AVG;
      seq0InputSelect       <= atam_pkg::RST_INPUT_SELECT_SLOT0;
      seq0LastSlot          <= atam_pkg::RST_LAST;
    end else begin
      if (selEnW && wStrb[0]) begin
        activeSequencerEnable <= wData[atam_pkg::NUM_SEQ-1:0];
      end
      if (selLastW && wStrb[0]) begin
        seq0LastSlot <= wData[atam_pkg::SLOT_W-1:0];
      end
      if (selPriW) begin
        sequencerPriority <= mergedPri;
      end
      if (selAvgW && wStrb[0]) begin
        averagingExponent <= wData[atam_pkg::EXP_W-1:0];
      end
      if (selMuxW) begin
        seq0InputSelect <= mergedMux;
      end
    end
  end

  // ---- arbitration among pending sequencers
  logic       anyPending;
  logic [1:0] winner;
  logic [atam_pkg::NUM_SEQ*atam_pkg::PRI_W-1:0] priField;

  atam_arb #(
    .NUM   (atam_pkg::NUM_SEQ),
    .PRI_W (atam_pkg::PRI_W)
  ) u_arb (
    .request  (pending),
    .level    (priField),
    .anyGrant (anyPending),
    .grantIdx (winner)
  );

  // compact the stride-four priority fields into adjacent pairs
  genvar g;
  generate
    for (g = 0; g < atam_pkg::NUM_SEQ; g++) begin : g_pri
      assign priField[g*atam_pkg::PRI_W +: atam_pkg::PRI_W] =
        sequencerPriority[g*atam_pkg::FIELD_STRIDE +: atam_pkg::PRI_W];
    end
  endgenerate

  wire launch  = (state == atam_pkg::ST_IDLE) && anyPending;
  wire [atam_pkg::NUM_SEQ-1:0] grantClr =
    launch ? atam_pkg::NUM_SEQ'(1 << winner) : '0;

  // pending triggers; a new trigger wins over the launch clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~grantClr) | trigSet;
    end
  end

  // ---- averaging stage
  logic                          avgLast;
  logic                          avgValid;
  logic [atam_pkg::SAMPLE_W-1:0] avgData;
  wire  sampleIn = (state == atam_pkg::ST_WAIT) && convDone;

  atam_avg #(
    .SAMPLE_W (atam_pkg::SAMPLE_W),
    .EXP_W    (atam_pkg::EXP_W),
    .MAX_EXP  (atam_pkg::MAX_EXP)
  ) u_avg (
    .clk         (clk),
    .rst_n       (rst_n),
    .exponent    (curExp),
    .sampleValid (sampleIn),
    .sampleData  (convData),
    .lastSample  (avgLast),
    .resultValid (avgValid),
    .resultData  (avgData)
  );

  // ---- slot input selection
  // sequencer 0 walks its slot selects from 0 to seq0LastSlot; the others hold one
  // slot and sample the input numbered like the sequencer
  wire [atam_pkg::SEL_W-1:0] slotSel =
    seq0InputSelect[curSlot*atam_pkg::FIELD_STRIDE +: atam_pkg::SEL_W];
  wire [atam_pkg::SEL_W-1:0] chanSel =
    (curSeq == 2'h0) ? slotSel : curSeq;
  wire [atam_pkg::SLOT_W-1:0] lastSlot =
    (curSeq == 2'h0) ? seq0LastSlot : '0;
  wire seqDone = (curSlot == lastSlot);

  // converter request: start is a one-cycle handshake pulse
  assign convReq.start   = (state == atam_pkg::ST_START);
  assign convReq.channel = chanSel;

  // next state
  always_comb begin
    next_state = state;
    case (state)
      atam_pkg::ST_IDLE: begin
        if (anyPending) begin
          next_state = atam_pkg::ST_START;
        end
      end
      atam_pkg::ST_START: begin
        next_state = atam_pkg::ST_WAIT;
      end
      atam_pkg::ST_WAIT: begin
        if (convDone) begin
          // more conversions needed for this average
          next_state = avgLast ? atam_pkg::ST_NEXT
                               : atam_pkg::ST_START;
        end
      end
      atam_pkg::ST_NEXT: begin
        next_state = seqDone ? atam_pkg::ST_IDLE : atam_pkg::ST_START;
      end
      default: begin
        next_state = atam_pkg::ST_IDLE;
      end
    endcase
  end

  // sequence bookkeeping; exponent is frozen per sequence so a
  // register write mid-average cannot corrupt the running sum
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= atam_pkg::ST_IDLE;
      curSeq  <= 2'h0;
      curSlot <= '0;
      curExp  <= atam_pkg::RST_AVG;
    end else begin
      state <= next_state;
      if (launch) begin
        curSeq  <= winner;
        curSlot <= '0;
        curExp  <= averagingExponent;
      end else if (state == atam_pkg::ST_NEXT && !seqDone) begin
        curSlot <= curSlot + 1'b1;
      end
    end
  end

  // result register toward the sequencer fifo
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result      <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= avgValid;
      if (avgValid) begin
        result.seq  <= curSeq;
        result.slot <= curSlot;
        result.data <= avgData;
      end
    end
  end

  assign busy = (state != atam_pkg::ST_IDLE);

  // ---- read path
  wire [31:0] statusWord =
    (32'(pending) << atam_pkg::ST_PEND_LSB) |
    (32'(busy)    << atam_pkg::ST_BUSY_BIT) |
    (32'(curSeq)  << atam_pkg::ST_SEQ_LSB)  |
    (32'(curSlot) << atam_pkg::ST_SLOT_LSB);

  wire [7:0] rAddr = {s_araddr[7:2], 2'b00};
  logic [31:0] readWord;
  logic        readOk;

  // read decode; initiate reads zero with no side effect
  always_comb begin
    readWord = 32'h0000_0000;
    readOk   = 1'b1;
    case (rAddr)
      atam_pkg::OFF_ENABLE:    readWord = 32'(activeSequencerEnable);
      atam_pkg::OFF_STATUS:    readWord = statusWord;
      atam_pkg::OFF_SEQ0_LAST: readWord = 32'(seq0LastSlot);
      atam_pkg::OFF_PRIORITY:  readWord = sequencerPriority;
      atam_pkg::OFF_INITIATE:  readWord = 32'h0000_0000;
      atam_pkg::OFF_AVG:       readWord = 32'(averagingExponent);
      atam_pkg::OFF_INPUT_SELECT_SLOT0:      readWord = seq0InputSelect;
      default:                 readOk   = 1'b0;
    endcase
  end

  assign s_arready = !s_rvalid;

  // read data is registered one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= atam_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= readWord;
      s_rresp  <= readOk ? atam_pkg::RESP_OKAY : atam_pkg::RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule : atam_top

// ==== test/atam_top_checker.sv ====
`timescale 1ns/1ns
module atam_top_checker (
  input wire logic                            clk,         // clock
  input wire logic                            rst_n,       // reset, low
  input wire logic [7:0]                      s_awaddr,    // aw
  input wire logic                            s_awvalid,   // aw
  input wire logic                            s_awready,   // aw
  input wire logic [31:0]                     s_wdata,     // w
  input wire logic [3:0]                      s_wstrb,     // w
  input wire logic                            s_wvalid,    // w
  input wire logic                            s_wready,    // w
  input wire logic [1:0]                      s_bresp,     // b
  input wire logic                            s_bvalid,    // b
  input wire logic                            s_bready,    // b
  input wire logic [7:0]                      s_araddr,    // ar
  input wire logic                            s_arvalid,   // ar
  input wire logic                            s_arready,   // ar
  input wire logic [31:0]                     s_rdata,     // r
  input wire logic [1:0]                      s_rresp,     // r
  input wire logic                            s_rvalid,    // r
  input wire logic                            s_rready,    // r
  input wire atam_pkg::atam_conv_s            convReq,     // request
  input wire logic                            convDone,    // done
  input wire logic [atam_pkg::SAMPLE_W-1:0]   convData,    // sample
  input wire atam_pkg::atam_result_s          result,      // result
  input wire logic                            resultValid, // pulse
  input wire logic                            busy         // running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // converter handshake shape
  property p_start_pulse; convReq.start |=> !convReq.start; endproperty
  property p_start_busy; convReq.start |=> busy; endproperty
  property p_launch; $rose(busy) |-> convReq.start; endproperty
  property p_chan; convReq.start |=> $stable(convReq.channel); endproperty
  // result pulse follows the closing conversion by two edges
  property p_res_pulse; resultValid |=> !resultValid; endproperty
  property p_res_cause; resultValid |-> $past(convDone, 2); endproperty
  property p_one_slot;
    resultValid && result.seq != 2'h0 |-> result.slot == 3'h0;
  endproperty
  // bus answers, fixed latency from the take edge
  property p_wr_answer;
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid;
  endproperty
  property p_rd_answer; s_arvalid && s_arready |=> s_rvalid; endproperty

  a_start_pulse: assert property (p_start_pulse)
    else $error("start held past one cycle");
  a_start_busy: assert property (p_start_busy)
    else $error("idle right after start");
  a_launch: assert property (p_launch)
    else $error("launch without start");
  a_chan: assert property (p_chan)
    else $error("channel moved inside slot");
  a_res_pulse: assert property (p_res_pulse)
    else $error("result valid too long");
  a_res_cause: assert property (p_res_cause)
    else $error("result without conversion");
  a_one_slot: assert property (p_one_slot)
    else $error("bad slot for short sequencer");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read response late");

  c_prio: cover property (resultValid && result.seq == 2'h2);
  c_avg: cover property (convDone ##2 resultValid);
  c_slot7: cover property (resultValid && result.slot == 3'h7);
endmodule : atam_top_checker

bind atam_top atam_top_checker u_chk (.clk, .rst_n, .s_awaddr, .s_awvalid,
  .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
  .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
  .s_rresp, .s_rvalid, .s_rready, .convReq, .convDone, .convData,
  .result, .resultValid, .busy);

// ==== test/tb_atam_top.sv ====
`timescale 1ns/1ns
module tb_atam_top;
  logic                   clk, rst_n, s_awvalid, s_wvalid, s_bready;
  logic                   s_arvalid, s_rready, convDone, busy;
  logic                   s_awready, s_wready, s_bvalid, s_arready;
  logic                   s_rvalid, resultValid;
  logic [7:0]             s_awaddr, s_araddr;
  logic [31:0]            s_wdata, s_rdata, rd, m;
  logic [3:0]             s_wstrb, stb;
  logic [1:0]             s_bresp, s_rresp, rs, ch;
  logic [9:0]             convData, d;
  atam_pkg::atam_conv_s   convReq;
  atam_pkg::atam_result_s result;
  atam_pkg::atam_result_s rq[$];
  logic [31:0]            eq[$];
  logic [7:0]             ra[6];
  logic [31:0]            rv[6];
  logic [1:0]             ord[4];
  int                     numErrors, cmpCount, cycles, seed, sum;

  atam_top uut (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready, .convReq, .convDone, .convData, .result, .resultValid,
    .busy);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // results are one-cycle pulses, so catch them away from the tests
  always @(negedge clk) if (resultValid === 1'b1) rq.push_back(result);

  // hang guard, far above the several hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  function automatic logic [9:0] avg_of(input int s, input int e);
    avg_of = 10'(s >> e);
  endfunction : avg_of

  // short sequencers convert the input named by their own number
  function automatic logic [1:0] exp_chan(input logic [1:0] s);
    exp_chan = (s == 2'h0) ? m[1:0] : s;
  endfunction : exp_chan

  function automatic logic [31:0] pop();
    pop = {17'h0, rq.pop_front()};
  endfunction : pop

  // bus write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] dv,
                     output logic [1:0] r);
    logic aw, w;
    @(posedge clk);
    aw = 1'b1;
    w = 1'b1;
    s_awaddr <= a;
    s_wdata <= dv;
    s_wstrb <= stb;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_awready === 1'b1) begin
        aw = 1'b0;
        s_awvalid <= 1'b0;
      end
      if (w && s_wready === 1'b1) begin
        w = 1'b0;
        s_wvalid <= 1'b0;
        s_bready <= 1'b1;
      end
    end
    while (s_bvalid !== 1'b1) @(posedge clk);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] dv,
                     output logic [1:0] r);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do @(posedge clk); while (s_rvalid !== 1'b1);
    dv = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : axr

  // converter stand-in; low data bits double as a stall length
  task automatic conv(input logic [9:0] dv, output logic [1:0] chn);
    do @(negedge clk); while (convReq.start !== 1'b1);
    chn = convReq.channel;
    repeat (dv[1:0]) @(posedge clk);
    @(posedge clk);
    convDone <= 1'b1;
    convData <= dv;
    @(posedge clk);
    convDone <= 1'b0;
    convData <= ~dv;
  endtask : conv

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, convDone, convData} = '0;
    numErrors = 0;
    cmpCount = 0;
    cycles = 0;
    stb = 4'hF;
    seed = 32'h021a2d00;
    rst_n = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // reset values; reading initiate leaves nothing pending
    ra = '{atam_pkg::OFF_PRIORITY, atam_pkg::OFF_AVG, atam_pkg::OFF_INPUT_SELECT_SLOT0,
           atam_pkg::OFF_SEQ0_LAST, atam_pkg::OFF_INITIATE,
           atam_pkg::OFF_STATUS};
    rv = '{32'h0000_3210, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0};
    foreach (ra[i]) begin
      axr(ra[i], rd, rs);
      check(rd, rv[i]);
    end
    axr(8'h3C, rd, rs);
    check(32'(rs), 32'(atam_pkg::RESP_SLVERR));
    axw(8'h3C, 32'hFFFF_FFFF, rs);
    check(32'(rs), 32'(atam_pkg::RESP_SLVERR));
    // select fields read back; reserved bits are written as zero
    rd = $random(seed);
    m = rd & atam_pkg::MASK_INPUT_SELECT_SLOT0;
    axw(atam_pkg::OFF_INPUT_SELECT_SLOT0, m, rs);
    axr(atam_pkg::OFF_INPUT_SELECT_SLOT0, rd, rs);
    check(rd, m);
    // low byte lane only: upper slots must keep their selects
    stb = 4'h1;
    axw(atam_pkg::OFF_INPUT_SELECT_SLOT0, 32'h3333_3333, rs);
    stb = 4'hF;
    m[7:0] = 8'h33;
    axr(atam_pkg::OFF_INPUT_SELECT_SLOT0, rd, rs);
    check(rd, m);
    $display("test registers done");
    // eight slots, no averaging
    axw(atam_pkg::OFF_ENABLE, 32'h1, rs);
    axw(atam_pkg::OFF_INITIATE, 32'h1, rs);
    for (int k = 0; k < 8; k++) begin
      d = 10'($random(seed));
      conv(d, ch);
      check(32'(ch), 32'(m[4*k +: 2]));
      eq.push_back({17'h0, 2'h0, 3'(k), d});
    end
    repeat (4) @(posedge clk);
    while (eq.size() != 0) check(pop(), eq.pop_front());
    $display("test slots done");
    // averaging exponents one to six, all-ones on odd samples at sixty-four
    axw(atam_pkg::OFF_SEQ0_LAST, 32'h0, rs);
    for (int e = 1; e <= 6; e++) begin
      axw(atam_pkg::OFF_AVG, 32'(e), rs);
      axw(atam_pkg::OFF_INITIATE, 32'h1, rs);
      sum = 0;
      for (int i = 0; i < (1 << e); i++) begin
        d = (e == 6 && i[0]) ? 10'h3FF : 10'($random(seed));
        conv(d, ch);
        sum += int'(d);
      end
      repeat (4) @(posedge clk);
      check(pop(), {22'h0, avg_of(sum, e)});
    end
    $display("test averaging done");
    // all four at once, order by priority field, not by index
    axw(atam_pkg::OFF_AVG, 32'h0, rs);
    axw(atam_pkg::OFF_ENABLE, 32'hF, rs);
    axw(atam_pkg::OFF_PRIORITY, 32'h0000_2013, rs);
    axw(atam_pkg::OFF_INITIATE, 32'hF, rs);
    ord = '{2'h2, 2'h1, 2'h3, 2'h0};
    foreach (ord[i]) begin
      d = 10'($random(seed));
      conv(d, ch);
      check(32'(ch), 32'(exp_chan(ord[i])));
      eq.push_back({17'h0, ord[i], 3'h0, d});
    end
    // disabled sequencers drop their trigger
    axw(atam_pkg::OFF_ENABLE, 32'h5, rs);
    axw(atam_pkg::OFF_INITIATE, 32'hF, rs);
    for (int i = 0; i < 2; i++) begin
      d = 10'($random(seed));
      conv(d, ch);
      eq.push_back({17'h0, i[0] ? 2'h0 : 2'h2, 3'h0, d});
    end
    repeat (8) @(posedge clk);
    check(32'(rq.size()), 32'h6);
    while (eq.size() != 0) check(pop(), eq.pop_front());
    check(32'(busy), 32'h0);
    $display("test priority done");
    test_done();
  end
endmodule : tb_atam_top
